//--- src/flash_host_pkg.sv
// Purpose: Shared constants and types for the parallel flash host controller.
// Assumes: One 100 MHz clock; all times are rounded up to whole clock cycles.
// Notes: Access, strobe and wake times are plain defaults; adjust to the part used.
package flash_host_pkg;

  // ---------------------------------------------------------------------------
  // Widths and clock
  // ---------------------------------------------------------------------------
  localparam int unsigned ADDR_W = 21;     // Word address space of 2M sixteen-bit locations.
  localparam int unsigned DATA_W = 16;     // All sixteen data lines.
  localparam int unsigned CNT_W = 16;      // Width of the timing counter.
  localparam int unsigned CLOCK_MHZ = 100; // Clock rate in MHz.
  localparam int unsigned NS_PER_US = 1000; // Nanoseconds in one microsecond.

  // ---------------------------------------------------------------------------
  // Times in nanoseconds
  // ---------------------------------------------------------------------------
  localparam int unsigned PD_LOW_NS = 100;      // Least low time of reset_powerdown_n.
  localparam int unsigned ACCESS_NS = 100;      // Read access allowance, plain default.
  localparam int unsigned WE_LOW_NS = 50;       // Write strobe low width, plain default.
  localparam int unsigned RECOVER_NS = 20;      // Idle gap between bus cycles, plain default.
  localparam int unsigned WAKE_WRITE_NS = 1000; // wake_to_write_time, plain default.
  localparam int unsigned WAKE_DATA_NS = 1000;  // wake_to_data_valid_time, plain default.

  // Rounds a least time up to whole cycles, never below one cycle.
  function automatic int unsigned ns_to_cycles(input int unsigned ns);
    int unsigned cyc;
    cyc = (ns * CLOCK_MHZ + NS_PER_US - 1) / NS_PER_US;
    return (cyc == 0) ? 1 : cyc;
  endfunction : ns_to_cycles

  // ---------------------------------------------------------------------------
  // Cycle counts
  // ---------------------------------------------------------------------------
  localparam logic [CNT_W-1:0] PD_CYCLES = CNT_W'(ns_to_cycles(PD_LOW_NS));
  localparam logic [CNT_W-1:0] ACCESS_CYCLES = CNT_W'(ns_to_cycles(ACCESS_NS));
  localparam logic [CNT_W-1:0] WE_CYCLES = CNT_W'(ns_to_cycles(WE_LOW_NS));
  localparam logic [CNT_W-1:0] RECOVER_CYCLES = CNT_W'(ns_to_cycles(RECOVER_NS));
  // The wake wait covers both the data-valid and the write interval.
  localparam logic [CNT_W-1:0] WAKE_CYCLES =
    CNT_W'((WAKE_WRITE_NS > WAKE_DATA_NS) ? ns_to_cycles(WAKE_WRITE_NS)
                                          : ns_to_cycles(WAKE_DATA_NS));
  localparam logic [CNT_W-1:0] WAKE_WRITE_CYCLES = CNT_W'(ns_to_cycles(WAKE_WRITE_NS));
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001; // Counter step.

  // One bus request from the user side.
  typedef struct packed {
    logic write;              // High for a command write, low for a read.
    logic [ADDR_W-1:0] addr;  // Target address.
    logic [DATA_W-1:0] data;  // Command or write data.
  } req_t;

  // Controller states, one-hot.
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_READ = 7'h02,
    ST_WSETUP = 7'h04,
    ST_WLOW = 7'h08,
    ST_WHOLD = 7'h10,
    ST_PDOWN = 7'h20,
    ST_WAKE = 7'h40
  } state_t;

endpackage : flash_host_pkg

//--- src/flash_host.sv
// Purpose: Host-side bus cycle engine that reads and writes a parallel flash.
// Assumes: Pins are synchronous to clock; the flash keeps its own protection rules.
// Notes: srst also holds the flash in deep power-down, so both reset together.
`timescale 1ns/1ps
module flash_host (
  input wire logic clock,
  input wire logic srst,
  input wire logic req_valid,
  input wire flash_host_pkg::req_t req,
  output logic req_ready,
  output logic rsp_valid,
  output logic [flash_host_pkg::DATA_W-1:0] rsp_data,
  input wire logic powerdown_req,
  output logic device_busy,
  output logic chip_select_a_n,
  output logic chip_select_b_n,
  output logic output_enable_n,
  output logic write_enable_n,
  output logic reset_powerdown_n,
  output logic [flash_host_pkg::ADDR_W-1:0] address,
  output logic [flash_host_pkg::DATA_W-1:0] data_out,
  output logic data_oe,
  input wire logic [flash_host_pkg::DATA_W-1:0] data_in,
  input wire logic busy_status_output
);

  // ---------------------------------------------------------------------------
  // State and counters
  // ---------------------------------------------------------------------------
  flash_host_pkg::state_t state_reg; // Current bus phase.
  flash_host_pkg::state_t state_next; // Next bus phase.
  logic [flash_host_pkg::CNT_W-1:0] cnt_reg; // Cycles left in the phase.
  logic [flash_host_pkg::CNT_W-1:0] cnt_next; // Next counter value.
  logic accept; // A request is taken this cycle.
  logic cycle_on_next; // Select is low in the next phase.

  // A request is only taken when the handshake completes.
  assign accept = req_valid && req_ready;
  assign cycle_on_next = (state_next == flash_host_pkg::ST_READ) ||
                         (state_next == flash_host_pkg::ST_WSETUP) ||
                         (state_next == flash_host_pkg::ST_WLOW) ||
                         (state_next == flash_host_pkg::ST_WHOLD);

  // Next-state logic; a taken request wins over a power-down request.
  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    unique case (state_reg)
      flash_host_pkg::ST_IDLE:
      begin
        if (cnt_reg != 0)
        begin
          // Recovery gap between bus cycles.
          cnt_next = cnt_reg - flash_host_pkg::CNT_ONE;
        end
        else if (accept && req.write)
        begin
          state_next = flash_host_pkg::ST_WSETUP;
        end
        else if (accept)
        begin
          state_next = flash_host_pkg::ST_READ;
          cnt_next = flash_host_pkg::ACCESS_CYCLES - flash_host_pkg::CNT_ONE;
        end
        else if (powerdown_req)
        begin
          state_next = flash_host_pkg::ST_PDOWN;
          cnt_next = flash_host_pkg::PD_CYCLES - flash_host_pkg::CNT_ONE;
        end
      end
      flash_host_pkg::ST_READ:
      begin
        if (cnt_reg == 0)
        begin
          state_next = flash_host_pkg::ST_IDLE;
          cnt_next = flash_host_pkg::RECOVER_CYCLES;
        end
        else
        begin
          cnt_next = cnt_reg - flash_host_pkg::CNT_ONE;
        end
      end
      flash_host_pkg::ST_WSETUP:
      begin
        // Select and data settle one cycle before the strobe falls.
        state_next = flash_host_pkg::ST_WLOW;
        cnt_next = flash_host_pkg::WE_CYCLES - flash_host_pkg::CNT_ONE;
      end
      flash_host_pkg::ST_WLOW:
      begin
        if (cnt_reg == 0)
        begin
          state_next = flash_host_pkg::ST_WHOLD;
        end
        else
        begin
          cnt_next = cnt_reg - flash_host_pkg::CNT_ONE;
        end
      end
      flash_host_pkg::ST_WHOLD:
      begin
        // The strobe has risen first; the select rises one cycle later.
        state_next = flash_host_pkg::ST_IDLE;
        cnt_next = flash_host_pkg::RECOVER_CYCLES;
      end
      flash_host_pkg::ST_PDOWN:
      begin
        if (cnt_reg != 0)
        begin
          cnt_next = cnt_reg - flash_host_pkg::CNT_ONE;
        end
        else if (!powerdown_req)
        begin
          state_next = flash_host_pkg::ST_WAKE;
          cnt_next = flash_host_pkg::WAKE_CYCLES - flash_host_pkg::CNT_ONE;
        end
      end
      flash_host_pkg::ST_WAKE:
      begin
        if (cnt_reg == 0)
        begin
          state_next = flash_host_pkg::ST_IDLE;
        end
        else
        begin
          cnt_next = cnt_reg - flash_host_pkg::CNT_ONE;
        end
      end
    endcase
  end

  // Phase register; reset starts in power-down so the flash resets with the system.
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      state_reg <= flash_host_pkg::ST_PDOWN;
      cnt_reg <= flash_host_pkg::PD_CYCLES - flash_host_pkg::CNT_ONE;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Pin strobes
  // ---------------------------------------------------------------------------
  // Strobes are registered from the next phase so they line up with state_reg.
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      chip_select_a_n <= 1'h1;
      chip_select_b_n <= 1'h1;
      output_enable_n <= 1'h1;
      write_enable_n <= 1'h1;
      reset_powerdown_n <= 1'h0;
      req_ready <= 1'h0;
    end
    else
    begin
      // Both selects move together; one high alone would only mean standby.
      chip_select_a_n <= !cycle_on_next;
      chip_select_b_n <= !cycle_on_next;
      // Only the read phase lowers output enable, never the write phases.
      output_enable_n <= (state_next != flash_host_pkg::ST_READ);
      write_enable_n <= (state_next != flash_host_pkg::ST_WLOW);
      reset_powerdown_n <= (state_next != flash_host_pkg::ST_PDOWN);
      req_ready <= (state_next == flash_host_pkg::ST_IDLE) && (cnt_next == 0);
    end
  end

  // ---------------------------------------------------------------------------
  // Address and data path
  // ---------------------------------------------------------------------------
  // Address and data are captured once per request and held for the whole cycle.
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      address <= '0;
      data_out <= '0;
      data_oe <= 1'h0;
    end
    else
    begin
      if (accept)
      begin
        address <= req.addr;
        data_out <= req.data;
      end
      // Data is driven only in write phases, so it never fights read data.
      data_oe <= (state_next == flash_host_pkg::ST_WSETUP) ||
                 (state_next == flash_host_pkg::ST_WLOW) ||
                 (state_next == flash_host_pkg::ST_WHOLD);
    end
  end

  // ---------------------------------------------------------------------------
  // Response and status
  // ---------------------------------------------------------------------------
  // Read data is sampled at the end of the access allowance.
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      rsp_valid <= 1'h0;
      rsp_data <= '0;
    end
    else
    begin
      rsp_valid <= (state_reg == flash_host_pkg::ST_READ) && (cnt_reg == 0);
      if ((state_reg == flash_host_pkg::ST_READ) && (cnt_reg == 0))
      begin
        rsp_data <= data_in;
      end
    end
  end

  // A floated status line reads high; low means the flash is busy.
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      device_busy <= 1'h0;
    end
    else
    begin
      device_busy <= !busy_status_output;
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  localparam int ACC_D = flash_host_pkg::ACCESS_CYCLES; // Read latency in cycles.
  logic [flash_host_pkg::CNT_W-1:0] low_cnt_reg; // Cycles with powerdown pin low.
  logic [flash_host_pkg::CNT_W-1:0] high_cnt_reg; // Cycles since powerdown pin rose.

  // Saturating counters over the powerdown pin, read only by the checks.
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      low_cnt_reg <= '0;
      high_cnt_reg <= '0;
    end
    else
    begin
      low_cnt_reg <= reset_powerdown_n ? '0 :
                     ((&low_cnt_reg) ? low_cnt_reg : low_cnt_reg + flash_host_pkg::CNT_ONE);
      high_cnt_reg <= !reset_powerdown_n ? '0 :
                      ((&high_cnt_reg) ? high_cnt_reg : high_cnt_reg + flash_host_pkg::CNT_ONE);
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  sequence write_strobe_rise;
    $rose(write_enable_n);
  endsequence

  sequence select_rise_after;
    !chip_select_a_n ##1 chip_select_a_n;
  endsequence

  chk_oe_we_excl: assert property (!(!output_enable_n && !write_enable_n))
    else $error("output enable and write strobe low together");
  chk_read_pins: assert property (!output_enable_n |->
      !chip_select_a_n && !chip_select_b_n && write_enable_n && reset_powerdown_n)
    else $error("read cycle with wrong control pins");
  chk_read_latency: assert property ($fell(output_enable_n) |-> ##ACC_D rsp_valid)
    else $error("read data not returned after access time");
  chk_data_float: assert property (!output_enable_n |-> !data_oe)
    else $error("host drives data during read");
  chk_pd_hold: assert property ($rose(reset_powerdown_n) |->
      low_cnt_reg >= flash_host_pkg::PD_CYCLES)
    else $error("powerdown pin low too briefly");
  chk_wake_write: assert property ($fell(write_enable_n) |->
      high_cnt_reg >= flash_host_pkg::WAKE_WRITE_CYCLES)
    else $error("command written too soon after wake-up");
  chk_pd_quiet: assert property (!reset_powerdown_n |->
      chip_select_a_n && output_enable_n && write_enable_n && !data_oe)
    else $error("bus cycle while powerdown pin low");
  chk_addr_hold: assert property (!write_enable_n && !$past(write_enable_n) |->
      $stable(address) && $stable(data_out) && data_oe)
    else $error("address or data moved during write strobe");
  chk_we_first: assert property (write_strobe_rise |-> select_rise_after)
    else $error("select did not rise one cycle after write strobe");

endmodule : flash_host

//--- verification/flash_part.sv
// Purpose: Behavioural parallel flash that answers the host controller's pins.
// Assumes: Operation time is a plain default; blocks are 64K sixteen-bit words wide.
// Notes: Floating data lines toggle every 5 ns, so a stale value never looks valid.
`timescale 1ns/1ps
module flash_part #(
  parameter int OP_NS = 2000, // Program and lock time, plain default.
  parameter logic [15:0] MAKER_CODE = 16'h00a7, // Arbitrary value.
  parameter logic [15:0] DEVICE_CODE = 16'h00d2 // Arbitrary value.
) (
  input wire logic chip_select_a_n,
  input wire logic chip_select_b_n,
  input wire logic output_enable_n,
  input wire logic write_enable_n,
  input wire logic reset_powerdown_n,
  input wire logic [flash_host_pkg::ADDR_W-1:0] address,
  input wire logic [15:0] data_out,
  input wire logic data_oe,
  input wire logic vpp_ok,
  input wire logic vcc_ok,
  output logic [15:0] data_in,
  output logic busy_status_output
);
  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  logic [15:0] mem [int]; // Written words; others hold the erased pattern.
  logic [31:0] locked = 32'h0; // One lock bit per block.
  logic [1:0] mode = 2'd0; // 0 array, 1 status, 2 identifier, 3 query.
  logic [1:0] pend = 2'd0; // 1 word write, 2 lock set awaited next.
  logic busy = 1'b0; // Internal operation running.
  logic [15:0] float_pat = 16'h0000; // Seen by the host when nobody drives.
  logic [15:0] q; // Data that the part would drive.
  int gen = 0; // Bumped to cancel a running timer.
  int mine = 0; // Timer's own copy of gen.
  wire wr_act = !write_enable_n && !chip_select_a_n && !chip_select_b_n;
  wire drive = reset_powerdown_n && !wr_act && !chip_select_a_n && !chip_select_b_n
    && !output_enable_n;

  function automatic logic [15:0] word(input logic [20:0] a);
    return mem.exists(int'(a)) ? mem[int'(a)] : (a[15:0] ^ 16'ha5c3);
  endfunction : word

  // ---------------------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------------------
  always #5 float_pat = ~float_pat;
  always_comb
  begin
    case (mode)
      2'd1: q = {8'h00, !busy, 7'h00};
      2'd2: q = (address[1:0] == 2'd0) ? MAKER_CODE : (address[1:0] == 2'd1) ? DEVICE_CODE
        : {15'h0, locked[address[20:16]]};
      2'd3: q = (address < 21'd48) ? {8'h00, address[7:0] ^ 8'h3c} : 16'h0000;
      default: q = word(address);
    endcase
  end
  assign data_in = data_oe ? data_out : (drive ? q : float_pat);
  // Floated status reads high through its pull-up.
  assign busy_status_output = !busy;

  // ---------------------------------------------------------------------------
  // Command entry: latched when the first of strobe or select rises
  // ---------------------------------------------------------------------------
  always @(negedge wr_act)
  begin
    if (reset_powerdown_n && vcc_ok && !busy)
    begin
      if (pend != 2'd0)
      begin
        if (vpp_ok && pend == 2'd1 && !locked[address[20:16]])
          mem[int'(address)] = word(address) & data_out;
        if (vpp_ok && pend == 2'd2 && data_out[7:0] == 8'h01)
          locked[address[20:16]] = 1'b1;
        pend = 2'd0;
        mode = 2'd1;
        busy = 1'b1;
      end
      else
        case (data_out[7:0])
          8'hff: mode = 2'd0;
          8'h70: mode = 2'd1;
          8'h90: mode = 2'd2;
          8'h98: mode = 2'd3;
          8'h40, 8'h10: pend = 2'd1;
          8'h60: pend = 2'd2;
          default: ;
        endcase
    end
  end

  // The timer ignores selects, so deselection never stops it.
  always @(posedge busy)
  begin
    mine = gen;
    #OP_NS;
    if (gen == mine)
      busy = 1'b0;
  end
  // Power-down aborts, keeps status low, and wakes in read array mode.
  always @(negedge reset_powerdown_n)
  begin
    gen = gen + 1;
    pend = 2'd0;
  end
  always @(posedge reset_powerdown_n)
  begin
    busy = 1'b0;
    mode = 2'd0;
  end
endmodule : flash_part

//--- verification/tb_flash_host.sv
// Purpose: Self-checking bench for the flash host controller.
// Assumes: Behavioural flash part stands at the far side.
// Notes: Every scenario is a task that drives and judges by itself.
`timescale 1ns/1ps
module tb_flash_host;
  localparam logic [15:0] MAKER = 16'h00a7; // Arbitrary value.
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic req_valid = 1'b0;
  flash_host_pkg::req_t req = '0;
  logic powerdown_req = 1'b0;
  logic vpp_ok = 1'b1;
  logic vcc_ok = 1'b1;
  logic req_ready, rsp_valid, device_busy, cs_a_n, cs_b_n, oe_n, we_n, rp_n, data_oe, sts;
  logic [15:0] rsp_data, data_out, data_in, rd;
  logic [20:0] address;
  int miscompares = 0;
  int check_count = 0;

  always #5 clock = ~clock;
  flash_host dut (.clock(clock), .srst(srst), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .powerdown_req(powerdown_req), .device_busy(device_busy), .chip_select_a_n(cs_a_n),
    .chip_select_b_n(cs_b_n), .output_enable_n(oe_n), .write_enable_n(we_n),
    .reset_powerdown_n(rp_n), .address(address), .data_out(data_out), .data_oe(data_oe),
    .data_in(data_in), .busy_status_output(sts));
  flash_part #(.MAKER_CODE(MAKER)) model (.chip_select_a_n(cs_a_n), .chip_select_b_n(cs_b_n),
    .output_enable_n(oe_n), .write_enable_n(we_n), .reset_powerdown_n(rp_n),
    .address(address), .data_out(data_out), .data_oe(data_oe), .vpp_ok(vpp_ok),
    .vcc_ok(vcc_ok), .data_in(data_in), .busy_status_output(sts));

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // One bus request: held from just after an edge until the edge that takes it.
  // Outputs are looked at 1 ns after an edge, where they have settled.
  task automatic access(input logic wr, input logic [20:0] a, input logic [15:0] d);
    int n;
    int m;
    n = 0;
    m = 0;
    @(posedge clock);
    #1 req = '{write: wr, addr: a, data: d};
    req_valid = 1'b1;
    // Ready is registered, so once it stands high the next edge takes the request.
    while (req_ready !== 1'b1 && n < 600)
    begin
      @(posedge clock);
      #1 n++;
    end
    @(posedge clock);
    #1 req_valid = 1'b0;
    while (!wr && rsp_valid !== 1'b1 && m < 40)
    begin
      @(posedge clock);
      #1 m++;
    end
    // A handshake that never completes counts as a mismatch.
    if (n >= 600 || m >= 40)
    begin
      miscompares++;
      $display("ERROR access wait expected done seen timeout");
    end
    // Only a read replaces the captured data, so old read data never leaks into polls.
    if (!wr)
      rd = rsp_data;
  endtask : access

  function automatic logic [15:0] erased(input logic [20:0] a);
    return a[15:0] ^ 16'ha5c3;
  endfunction : erased

  // Polls status until ready, then returns to read array mode.
  task automatic settle;
    rd = 16'h0000;
    access(1'b1, 21'h0, 16'h0070);
    for (int k = 0; k < 30 && rd !== 16'h0080; k++)
      access(1'b0, 21'h0, 16'h0);
    check("status ready", 16'h0080, rd);
    access(1'b1, 21'h0, 16'h00ff);
  endtask : settle

  task automatic t_reset;
    check("rp low in reset", 16'h0, {15'h0, rp_n});
    vpp_ok = 1'b0;
    #1 srst = 1'b0;
    access(1'b0, 21'h00_1234, 16'h0);
    check("first read", erased(21'h00_1234), rd);
    vpp_ok = 1'b1;
  endtask : t_reset

  task automatic t_modes;
    access(1'b1, 21'h0, 16'h0070);
    access(1'b0, 21'h0, 16'h0);
    check("status", 16'h0080, rd);
    access(1'b0, 21'h10, 16'h0);
    check("status again", 16'h0080, rd);
    access(1'b1, 21'h0, 16'h0090);
    access(1'b0, 21'h0, 16'h0);
    check("maker", MAKER, rd);
    access(1'b1, 21'h0, 16'h0098);
    access(1'b0, 21'd47, 16'h0);
    check("query 47", {8'h00, 8'd47 ^ 8'h3c}, rd);
    access(1'b0, 21'd48, 16'h0);
    check("query 48", 16'h0000, rd);
    access(1'b1, 21'h0, 16'h00ff);
  endtask : t_modes

  task automatic t_program;
    access(1'b1, 21'h02_0010, 16'h0040);
    access(1'b1, 21'h02_0010, 16'h0f0f);
    // The strobe rises several cycles after the take; let the status show.
    repeat (10) @(posedge clock);
    #1 check("busy", 16'h1, {15'h0, device_busy});
    settle();
    access(1'b1, 21'h02_0020, 16'h0000);
    access(1'b0, 21'h02_0010, 16'h0);
    check("programmed", erased(21'h02_0010) & 16'h0f0f, rd);
    access(1'b0, 21'h02_0020, 16'h0);
    check("stray write", erased(21'h02_0020), rd);
  endtask : t_program

  task automatic t_protect;
    vpp_ok = 1'b0;
    access(1'b1, 21'h04_0000, 16'h0040);
    access(1'b1, 21'h04_0000, 16'h0000);
    settle();
    access(1'b0, 21'h04_0000, 16'h0);
    check("low supply", erased(21'h04_0000), rd);
    vpp_ok = 1'b1;
    access(1'b1, 21'h03_0000, 16'h0060);
    access(1'b1, 21'h03_0000, 16'h0001);
    settle();
    access(1'b1, 21'h03_0100, 16'h0040);
    access(1'b1, 21'h03_0100, 16'h0000);
    settle();
    access(1'b0, 21'h03_0100, 16'h0);
    check("locked block", erased(21'h03_0100), rd);
    // A low core supply must refuse the whole write sequence.
    vcc_ok = 1'b0;
    access(1'b1, 21'h04_0010, 16'h0040);
    access(1'b1, 21'h04_0010, 16'h0000);
    access(1'b0, 21'h04_0010, 16'h0);
    vcc_ok = 1'b1;
    check("low core supply", erased(21'h04_0010), rd);
  endtask : t_protect

  task automatic t_powerdown;
    int low;
    low = 0;
    access(1'b1, 21'h05_0000, 16'h0040);
    access(1'b1, 21'h05_0000, 16'h0000);
    @(posedge clock);
    #1 powerdown_req = 1'b1;
    repeat (40)
    begin
      @(posedge clock);
      low += (rp_n === 1'b0);
    end
    check("abort status", 16'h1, {15'h0, device_busy});
    #1 powerdown_req = 1'b0;
    check("low time", 16'h1, {15'h0, low >= 10});
    access(1'b0, 21'h06_0006, 16'h0);
    check("wake array", erased(21'h06_0006), rd);
  endtask : t_powerdown

  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out

  initial
  begin
    #200000;
    miscompares++;
    close_out();
  end

  initial
  begin
    repeat (10) @(posedge clock);
    t_reset();
    t_modes();
    t_program();
    t_protect();
    t_powerdown();
    close_out();
  end
endmodule : tb_flash_host
